//--- esl_pkg.sv
// shared constants and types for the front-panel status lamp block
// assumes a 25 MHz system clock; all status inputs come from the same clock
package esl_pkg;

	// clock and flash timing
	localparam int CLK_HZ = 25_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam logic [3:0] GAP_HALVES = 4'h4;

	// register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_LAMPS = 4'h4;
	localparam logic [3:0] OFS_RUN = 4'h8;

	// register fields
	localparam int CTRL_VAR_LSB = 0;
	localparam int RUN_CODE_LSB = 0;
	localparam int RUN_STATE_LSB = 4;

	// module variants
	localparam logic [1:0] VAR_STD = 2'h0;
	localparam logic [1:0] VAR_ALT = 2'h1;
	localparam logic [1:0] VAR_10BT = 2'h2;
	localparam logic [1:0] CTRL_RST = VAR_STD;

	// run lamp flash codes
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_NO_LINK = 4'h3;
	localparam logic [3:0] CODE_DUP_IP = 4'h4;
	localparam logic [3:0] CODE_NO_IP = 4'h5;
	localparam logic [3:0] CODE_BAD_IP = 4'h6;
	localparam logic [3:0] CODE_NO_EXEC = 4'h7;
	localparam logic [3:0] CODE_FFS = 4'h9;

	// status reported by the rest of the module
	typedef struct packed {
		logic backplane_cfg;
		logic healthy;
		logic crash;
		logic collision;
		logic link_up;
		logic tx_act;
		logic rx_act;
		logic speed_100;
		logic full_duplex;
		logic kernel_mode;
		logic download_mode;
		logic crash_log;
		logic cable_missing;
		logic dup_ip;
		logic no_ip;
		logic bad_ip;
		logic no_exec;
		logic ffs_bad;
		logic error_det;
		logic dl_failed;
		logic reset_busy;
	} esl_stat_t;

	// lamp drives, one bit per lamp, high lights it
	typedef struct packed {
		logic active;
		logic ready;
		logic fault;
		logic run;
		logic coll;
		logic link;
		logic tx;
		logic rx;
		logic low_speed_lamp;
		logic high_speed_lamp;
		logic fduplex;
		logic kernel;
		logic appl;
	} esl_lamp_t;

	typedef enum logic [3:0] {
		RUN_STEADY = 4'h1,
		RUN_ON = 4'h2,
		RUN_OFF = 4'h4,
		RUN_GAP = 4'h8
	} esl_run_t;

endpackage

//--- esl_lamps.sv
// front-panel status lamp driver with an Avalon-MM register slave
// assumes status inputs are synchronous to clk; lamps drive plain LEDs
//
// Summary of operation
// - active lamp on when backplane configured
// - ready lamp on when module healthy
// - fault lamp flashes in crash state
// - collision lamp flashes during collisions
// - link lamp steady while link active
// - transmit lamp flashes on transmit activity
// - receive lamp flashes on receive activity
// - exactly one speed lamp, by rate
// - duplex lamp on in full duplex
// - kernel lamp steady kernel, flashing download
// - crash-log lamp on with log entry
// - run lamp steady in normal operation
// - three flashes when no link
// - four flashes, duplicate IP address
// - five flashes, no IP address
// - seven flashes, no executive firmware
// - nine flashes, alternate file system failure
// - 10Base-T collision lamp steady when unplugged
// - 10Base-T fault lamp on error/failure/reset
`timescale 1ns/1ps
`default_nettype none

module esl_lamps
	import esl_pkg::*;
#(
	parameter int HALF_CYC = FLASH_HALF_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// module status
	input wire esl_stat_t stat,
	// lamps and address policy
	output esl_lamp_t lamps,
	output logic use_default_ip,
	output logic stay_offline
);

	localparam int TW = $clog2(HALF_CYC + 1);

	// lowest active code wins; file system code exists only in the alternate
	function automatic logic [3:0] pick_code(input esl_stat_t s,
		input logic [1:0] v);
		logic [3:0] c;
		c = CODE_NONE;
		if (s.cable_missing)
			c = CODE_NO_LINK;
		else if (s.dup_ip)
			c = CODE_DUP_IP;
		else if (s.no_ip)
			c = CODE_NO_IP;
		else if (s.bad_ip)
			c = CODE_BAD_IP;
		else if (s.no_exec)
			c = CODE_NO_EXEC;
		else if (s.ffs_bad && v == VAR_ALT)
			c = CODE_FFS;
		return c;
	endfunction

	logic [TW-1:0] tick_cnt_r;
	logic tick;
	logic phase_r;
	logic [1:0] var_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic tx_hold_r;
	logic rx_hold_r;
	esl_run_t run_r;
	logic [3:0] code_r;
	logic [3:0] left_r;
	logic [3:0] want;
	logic normal;
	esl_lamp_t lamps_r;
	esl_lamp_t lamps_nxt;
	logic defip_r;
	logic offline_r;

	////////////////////////////////////////////////////////////////////////
	// flash timebase

	// one tick every half flash period; all blinking but the run lamp codes shares one phase
	always_ff @(posedge clk) begin
		if (!resetn)
			tick_cnt_r <= '0;
		else if (tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 1'b1;
	end

	assign tick = (tick_cnt_r == TW'(HALF_CYC - 1));

	always_ff @(posedge clk) begin
		if (!resetn)
			phase_r <= 1'b0;
		else if (tick)
			phase_r <= ~phase_r;
	end

	////////////////////////////////////////////////////////////////////////
	// register slave: one wait state, then the answer

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;

	always_ff @(posedge clk) begin
		if (!resetn)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	// read data captured one cycle ahead so it stands with the answer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_r <= 32'h0;
		end else if (avs_read && !ack_r) begin
			rdata_r <= 32'h0;
			case (avs_address)
				OFS_CTRL: rdata_r[CTRL_VAR_LSB +: 2] <= var_r;
				OFS_LAMPS: rdata_r[$bits(esl_lamp_t)-1:0] <= lamps_r;
				OFS_RUN: begin
					rdata_r[RUN_CODE_LSB +: 4] <= code_r;
					rdata_r[RUN_STATE_LSB +: 4] <= run_r;
				end
				default: rdata_r <= 32'h0;
			endcase
		end
	end

	// variant select; writes elsewhere are dropped
	always_ff @(posedge clk) begin
		if (!resetn)
			var_r <= CTRL_RST;
		else if (avs_write && ack_r && avs_address == OFS_CTRL &&
			avs_byteenable[0])
			var_r <= avs_writedata[CTRL_VAR_LSB +: 2];
	end

	////////////////////////////////////////////////////////////////////////
	// activity stretchers

	// a pulse shorter than a flash still shows; new activity beats the clear
	always_ff @(posedge clk) begin
		if (!resetn)
			tx_hold_r <= 1'b0;
		else if (stat.tx_act)
			tx_hold_r <= 1'b1;
		else if (tick && phase_r)
			tx_hold_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			rx_hold_r <= 1'b0;
		else if (stat.rx_act)
			rx_hold_r <= 1'b1;
		else if (tick && phase_r)
			rx_hold_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// run lamp flash code sequencer

	assign want = pick_code(stat, var_r);
	assign normal = stat.healthy && want == CODE_NONE;

	// a started code always plays out; the choice is only made again in gap
	always_ff @(posedge clk) begin
		if (!resetn) begin
			run_r <= RUN_STEADY;
			code_r <= CODE_NONE;
			left_r <= 4'h0;
		end else if (tick) begin
			case (run_r)
				RUN_STEADY: begin
					if (want != CODE_NONE) begin
						run_r <= RUN_ON;
						code_r <= want;
						left_r <= want;
					end
				end
				RUN_ON: run_r <= RUN_OFF;
				RUN_OFF: begin
					if (left_r == 4'h1) begin
						run_r <= RUN_GAP;
						left_r <= GAP_HALVES;
					end else begin
						run_r <= RUN_ON;
						left_r <= left_r - 4'h1;
					end
				end
				RUN_GAP: begin
					if (left_r != 4'h1) begin
						left_r <= left_r - 4'h1;
					end else if (want != CODE_NONE) begin
						run_r <= RUN_ON;
						code_r <= want;
						left_r <= want;
					end else begin
						run_r <= RUN_STEADY;
						code_r <= CODE_NONE;
					end
				end
				default: begin
					run_r <= RUN_STEADY;
					code_r <= CODE_NONE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lamp mapping

	always_comb begin
		lamps_nxt = '0;
		lamps_nxt.active = stat.backplane_cfg;
		lamps_nxt.ready = stat.healthy;
		lamps_nxt.run = (run_r == RUN_ON) ||
			(run_r == RUN_STEADY && normal);
		lamps_nxt.link = stat.link_up;
		lamps_nxt.tx = tx_hold_r && phase_r;
		lamps_nxt.rx = rx_hold_r && phase_r;
		lamps_nxt.low_speed_lamp = !stat.speed_100;
		lamps_nxt.high_speed_lamp = stat.speed_100;
		lamps_nxt.fduplex = stat.full_duplex;
		lamps_nxt.appl = stat.crash_log;
		// download flashing outranks the steady kernel indication
		if (stat.download_mode)
			lamps_nxt.kernel = phase_r;
		else
			lamps_nxt.kernel = stat.kernel_mode;
		if (var_r == VAR_10BT) begin
			lamps_nxt.fault = stat.error_det || stat.dl_failed ||
				stat.reset_busy;
			if (stat.cable_missing)
				lamps_nxt.coll = 1'b1;
			else
				lamps_nxt.coll = stat.collision && phase_r;
		end else begin
			lamps_nxt.fault = stat.crash && phase_r;
			lamps_nxt.coll = stat.collision && phase_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			lamps_r <= '0;
		else
			lamps_r <= lamps_nxt;
	end

	assign lamps = lamps_r;

	// address policy follows the variant
	always_ff @(posedge clk) begin
		if (!resetn) begin
			defip_r <= 1'b0;
			offline_r <= 1'b0;
		end else begin
			defip_r <= (var_r == VAR_STD && (stat.dup_ip || stat.no_ip)) ||
				stat.bad_ip;
			offline_r <= var_r == VAR_ALT && stat.dup_ip;
		end
	end

	assign use_default_ip = defip_r;
	assign stay_offline = offline_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// counts lit halves of one code sequence
	logic [3:0] pulses_r;
	always_ff @(posedge clk) begin
		if (!resetn)
			pulses_r <= 4'h0;
		else if (tick && run_r == RUN_ON)
			pulses_r <= pulses_r + 4'h1;
		else if (run_r == RUN_GAP || run_r == RUN_STEADY)
			pulses_r <= 4'h0;
	end

	active_lamp_a: assert property (
		$past(resetn) |-> lamps.active == $past(stat.backplane_cfg))
		else $error("active lamp does not follow backplane state");
	ready_lamp_a: assert property (
		$past(resetn) |-> lamps.ready == $past(stat.healthy))
		else $error("ready lamp does not follow health");
	speed_lamps_a: assert property (
		$past(resetn) |-> $onehot({lamps.low_speed_lamp,
		lamps.high_speed_lamp}))
		else $error("speed lamps not exactly one");
	fault_dark_a: assert property (
		!stat.crash && var_r != VAR_10BT |=> !lamps.fault)
		else $error("fault lamp lit without crash");
	coll_steady_a: assert property (
		var_r == VAR_10BT && stat.cable_missing |=> lamps.coll)
		else $error("collision lamp dark with cable missing");
	fault_10bt_a: assert property (
		var_r == VAR_10BT && stat.reset_busy |=> lamps.fault)
		else $error("fault lamp dark during reset");
	kernel_lamp_a: assert property (
		stat.kernel_mode && !stat.download_mode |=> lamps.kernel)
		else $error("kernel lamp dark in kernel mode");
	code_pick_a: assert property (
		stat.cable_missing |-> want == CODE_NO_LINK)
		else $error("lowest flash code not chosen");
	pulse_count_a: assert property (
		run_r == RUN_OFF && tick && left_r == 4'h1 |-> pulses_r == code_r)
		else $error("flash count differs from code");
	gap_dark_a: assert property (
		run_r == RUN_GAP ##1 run_r == RUN_GAP |-> !lamps.run)
		else $error("run lamp lit during gap");
	code_hold_a: assert property (
		run_r == RUN_ON && !tick |=> $stable(code_r))
		else $error("flash code changed mid sequence");
	offline_a: assert property (
		var_r == VAR_ALT && stat.dup_ip |=> stay_offline && !use_default_ip)
		else $error("alternate variant not kept off-line");

	no_link_c: cover property (run_r == RUN_GAP && code_r == CODE_NO_LINK);
	ffs_code_c: cover property (run_r == RUN_ON && code_r == CODE_FFS);
	back_normal_c: cover property (run_r == RUN_GAP ##1 run_r == RUN_STEADY);
	bus_write_c: cover property (avs_write && !avs_waitrequest);

endmodule

`default_nettype wire

//--- esl_panel.sv
// operator view of the run lamp: counts the flashes of each group
// assumes lamps change on clk; a group ends after a dark spell of two halves
`timescale 1ns/1ps
`default_nettype none

module esl_panel #(
	parameter int HALF = 8
) (
	// clock
	input wire logic clk,
	// lamp seen
	input wire logic run,
	// flashes of the last whole group
	output logic [3:0] count,
	output logic done
);
	logic prev_r = 1'b0;
	logic [3:0] acc_r = 4'h0;
	int dark_r = 0;

	// count rises; a long dark spell closes the group, steady light never does
	always_ff @(posedge clk) begin
		prev_r <= run;
		done <= 1'b0;
		dark_r <= run ? 0 : dark_r + 1;
		if (run && !prev_r) begin
			acc_r <= acc_r + 4'h1;
		end
		if (!run && dark_r == 2 * HALF + 1) begin
			count <= acc_r;
			acc_r <= 4'h0;
			done <= (acc_r != 4'h0);
		end
	end
endmodule
`default_nettype wire

//--- esl_lamps_tb.sv
// self-checking bench: bus tasks, status stimulus, run lamp flash counting
// assumes esl_lamps with a short flash half and esl_panel as the viewer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("Error at %0t: got %0h want %0h", $time, a, b); end end

module esl_lamps_tb;
	import esl_pkg::*;
	localparam int HALF = 8;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic wait_q;
	esl_stat_t st = esl_stat_t'(21'h0);
	esl_lamp_t lamps;
	logic [12:0] lv;
	logic dflt;
	logic offl;
	logic [3:0] cnt;
	logic [3:0] pcnt;
	logic done;
	logic [31:0] q;
	logic [1:0] seen;
	int mismatches = 0;
	int n_compared = 0;
	int i;

	assign lv = lamps;
	always #20 clk = ~clk;

	esl_lamps #(.HALF_CYC(HALF)) esl_lamps_i (.clk(clk), .resetn(resetn),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wait_q), .stat(st), .lamps(lamps),
		.use_default_ip(dflt), .stay_offline(offl));
	esl_panel #(.HALF(HALF)) esl_panel_i (.clk(clk), .run(lamps.run),
		.count(pcnt), .done(done));

	// one bus cycle; held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_q !== 1'b0 && n < 50);
		if (n >= 50)
			mismatches++;
		r = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	// new status, then time for the lamps to follow
	task automatic set(input logic [20:0] m);
		st <= esl_stat_t'(m);
		repeat (3) @(posedge clk);
	endtask

	// which levels a lamp shows over two flash periods
	task automatic look(input int b, output logic [1:0] s);
		s = 2'h0;
		repeat (4 * HALF) begin
			@(posedge clk);
			if (lv[b] === 1'b1) s[1] = 1'b1;
			if (lv[b] === 1'b0) s[0] = 1'b1;
		end
	endtask

	// second whole group, so a group in progress may finish first
	task automatic grp(output logic [3:0] c);
		int n;
		repeat (2) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (done !== 1'b1 && n < 800);
			if (n >= 800)
				mismatches++;
		end
		c = pcnt;
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// hang guard, well past the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		bus(1'b0, OFS_CTRL, 32'h0, q);
		`CHK(q, 32'h0)
		bus(1'b0, OFS_LAMPS, 32'h0, q);
		`CHK(q, 32'h10)
		// steady lamps, high speed, normal run
		set(21'h193A00);
		`CHK(lv, 13'h1A8F)
		look(9, seen);
		`CHK(seen, 2'h2)
		bus(1'b0, OFS_RUN, 32'h0, q);
		`CHK(q, 32'h10)
		set(21'h0);
		`CHK(lv, 13'h0010)
		// flashing lamps: fault, collision, tx, rx, download
		set(21'h06C400);
		for (i = 0; i < 5; i++) begin
			look(i == 0 ? 10 : i == 1 ? 8 : i == 2 ? 6 : i == 3 ? 5 : 1, seen);
			`CHK(seen, 2'h3)
		end
		// run codes 3..7 in the standard variant
		for (i = 0; i < 5; i++) begin
			set(21'h80000 | (21'h100 >> i));
			grp(cnt);
			`CHK(cnt, 4'(3 + i))
			`CHK(dflt, (i >= 1 && i <= 3))
		end
		set(21'h80110);
		grp(cnt);
		`CHK(cnt, CODE_NO_LINK)
		// alternate variant
		bus(1'b1, OFS_CTRL, 32'h1, q);
		bus(1'b0, OFS_CTRL, 32'h0, q);
		`CHK(q, 32'h1)
		set(21'h80008);
		grp(cnt);
		`CHK(cnt, CODE_FFS)
		set(21'h80080);
		grp(cnt);
		`CHK(cnt, CODE_DUP_IP)
		`CHK({offl, dflt}, 2'h2)
		// refused writes
		bus(1'b1, 4'hC, 32'h2, q);
		bus(1'b0, 4'hC, 32'h0, q);
		`CHK(q, 32'h0)
		be <= 4'h0;
		bus(1'b1, OFS_CTRL, 32'h2, q);
		be <= 4'hF;
		bus(1'b0, OFS_CTRL, 32'h0, q);
		`CHK(q, 32'h1)
		// 10Base-T variant
		bus(1'b1, OFS_CTRL, 32'h2, q);
		for (i = 0; i < 3; i++) begin
			set(21'h80004 >> i | 21'h80000);
			look(10, seen);
			`CHK(seen, 2'h2)
		end
		set(21'h80100);
		look(8, seen);
		`CHK(seen, 2'h2)
		set(21'h20000);
		look(8, seen);
		`CHK(seen, 2'h3)
		tally_and_finish();
	end
endmodule
`undef CHK
`default_nettype wire
